/* File: hdl/dod_pkg.sv */
// constants, types and ALU arithmetic of the dual-operand decode/execute core
`default_nettype none
package dod_pkg;

  // opcodes of the two-operand format
  localparam logic [3:0] OP_MOVE           = 4'h4;
  localparam logic [3:0] OP_ADD            = 4'h5;
  localparam logic [3:0] OP_ADD_CARRY      = 4'h6;
  localparam logic [3:0] OP_SUBTRACT_CARRY = 4'h7;
  localparam logic [3:0] OP_SUBTRACT       = 4'h8;
  localparam logic [3:0] OP_COMPARE        = 4'h9;
  localparam logic [3:0] OP_DECIMAL_ADD    = 4'hA;
  localparam logic [3:0] OP_BIT_TEST       = 4'hB;
  localparam logic [3:0] OP_BIT_CLEAR      = 4'hC;
  localparam logic [3:0] OP_BIT_SET        = 4'hD;
  localparam logic [3:0] OP_XOR            = 4'hE;
  localparam logic [3:0] OP_AND            = 4'hF;
  // format prefixes and count of one-operand codes
  localparam logic [5:0] FMT_ONE_PREFIX    = 6'h04;
  localparam logic [2:0] FMT_JUMP_PREFIX   = 3'h1;
  localparam logic [2:0] ONE_OP_COUNT      = 3'h7;
  // addressing encodings
  localparam logic [1:0] SM_REG            = 2'h0;
  localparam logic [1:0] SM_INDEX          = 2'h1;
  localparam logic [1:0] SM_INDIRECT       = 2'h2;
  localparam logic [1:0] SM_AUTOINC        = 2'h3;
  localparam logic       DM_REG            = 1'b0;
  localparam logic       DM_INDEX          = 1'b1;
  // core registers and status bits
  localparam logic [3:0] REG_PC            = 4'h0;
  localparam logic [3:0] REG_SR            = 4'h2;
  localparam int         SR_C              = 0;
  localparam int         SR_Z              = 1;
  localparam int         SR_N              = 2;
  localparam int         SR_V              = 8;
  localparam logic [15:0] INC_WORD         = 16'h0002;
  localparam logic [15:0] INC_BYTE         = 16'h0001;
  // bus map (byte addresses)
  localparam logic [9:0] OFS_CTRL          = 10'h000;
  localparam logic [9:0] OFS_STATUS        = 10'h004;
  localparam logic [9:0] OFS_REGS          = 10'h040;
  localparam logic [9:0] OFS_MEM           = 10'h100;
  localparam int         CTRL_RUN          = 0;
  localparam int         CTRL_STEP         = 1;
  localparam int         STAT_BUSY         = 0;
  localparam int         STAT_FAULT        = 1;

  // instruction word, msb first
  typedef struct packed {
    logic [3:0] opcode;
    logic [3:0] src_reg;
    logic       dst_mode;
    logic       size_byte;
    logic [1:0] src_mode_bits;
    logic [3:0] dst_reg;
  } dod_instr_t;

  typedef enum logic [1:0] {FMT_TWO, FMT_ONE, FMT_JUMP, FMT_NONE} dod_fmt_t;

  typedef struct packed {
    logic [15:0] result;
    logic        v;
    logic        n;
    logic        z;
    logic        c;
    logic        wr_dst;
    logic        upd_flags;
  } dod_alu_t;

  function automatic dod_fmt_t dod_decode_fmt(input logic [15:0] w);
    dod_fmt_t f;
    f = FMT_NONE;
    if (w[15:14] != 2'b00)
    begin
      f = FMT_TWO;
    end
    else if (w[15:13] == FMT_JUMP_PREFIX)
    begin
      f = FMT_JUMP;
    end
    else if (w[15:10] == FMT_ONE_PREFIX && w[9:7] < ONE_OP_COUNT)
    begin
      f = FMT_ONE;
    end
    return f;
  endfunction

  function automatic dod_alu_t dod_alu(input logic [3:0] op, input logic [15:0] src,
                                       input logic [15:0] dst, input logic byte_op,
                                       input logic cin);
    dod_alu_t    r;
    logic [15:0] mask;
    logic [15:0] s;
    logic [15:0] d;
    logic [15:0] a;
    logic [16:0] sum;
    logic [4:0]  dig;
    logic        dc;
    int          msb;
    r    = '0;
    msb  = byte_op ? 7 : 15;
    mask = byte_op ? 16'h00FF : 16'hFFFF;
    s    = src & mask;
    d    = dst & mask;
    a    = s;
    sum  = 17'h0_0000;
    dig  = 5'h00;
    dc   = cin;
    r.wr_dst    = 1'b1;
    r.upd_flags = 1'b1;
    case (op)
      OP_MOVE:
      begin
        r.result    = s;
        r.upd_flags = 1'b0;
      end
      OP_ADD, OP_ADD_CARRY:
      begin
        sum = {1'b0, s} + {1'b0, d} + {16'h0000, (op == OP_ADD_CARRY) & cin};
      end
      OP_SUBTRACT, OP_COMPARE, OP_SUBTRACT_CARRY:
      begin
        a   = ~s & mask;
        sum = {1'b0, d} + {1'b0, a} + {16'h0000, (op == OP_SUBTRACT_CARRY) ? cin : 1'b1};
        r.wr_dst = (op != OP_COMPARE);
      end
      OP_DECIMAL_ADD:
      begin
        for (int i = 0; i < 4; i++)
        begin
          if (i < (byte_op ? 2 : 4))
          begin
            dig = {1'b0, s[4*i +: 4]} + {1'b0, d[4*i +: 4]} + {4'h0, dc};
            if (dig > 5'h09)
            begin
              dig = dig + 5'h06;
            end
            r.result[4*i +: 4] = dig[3:0];
            dc = dig[4];
          end
        end
        r.c = dc;
      end
      // and forms; bit test keeps destination
      OP_BIT_TEST, OP_AND:
      begin
        r.result = s & d;
        r.wr_dst = (op == OP_AND);
      end
      OP_BIT_CLEAR:
      begin
        r.result    = ~s & d;
        r.upd_flags = 1'b0;
      end
      OP_BIT_SET:
      begin
        r.result    = s | d;
        r.upd_flags = 1'b0;
      end
      OP_XOR:
      begin
        r.result = s ^ d;
        r.v      = s[msb] & d[msb];
      end
      default:
      begin
        r.wr_dst    = 1'b0;
        r.upd_flags = 1'b0;
      end
    endcase
    if (op inside {OP_ADD, OP_ADD_CARRY, OP_SUBTRACT, OP_COMPARE, OP_SUBTRACT_CARRY})
    begin
      r.result = sum[15:0] & mask;
      r.c      = byte_op ? sum[8] : sum[16];
      r.v      = (a[msb] == d[msb]) && (r.result[msb] != d[msb]);
    end
    r.n = r.result[msb];
    r.z = (r.result == 16'h0000);
    if (op inside {OP_BIT_TEST, OP_AND, OP_XOR})
    begin
      r.c = !r.z;
    end
    return r;
  endfunction

endpackage
`default_nettype wire

/* File: hdl/dod_core.sv */
// dual-operand decode/execute core with flip-flop memory behind an Avalon-MM slave
`timescale 1ns/10ps
`default_nettype none
module dod_core
  import dod_pkg::*;
#(
  parameter int MEM_WORDS = 64
)
(
  // clock and reset
  input  wire logic        CLK_I,
  input  wire logic        RSTN_I,
  // avalon-mm slave
  input  wire logic [9:0]  AVS_ADDRESS_I,
  input  wire logic        AVS_READ_I,
  input  wire logic        AVS_WRITE_I,
  input  wire logic [31:0] AVS_WRITEDATA_I,
  input  wire logic [3:0]  AVS_BYTEENABLE_I,
  output logic [31:0]      AVS_READDATA_O,
  output logic             AVS_WAITREQUEST_O,
  // core status
  output logic             BUSY_O,
  output logic             FAULT_O
);

  // ****************************************
  // types
  // ****************************************
  typedef logic [MEM_WORDS-1:0][15:0] dod_mem_t;
  typedef logic [15:0][15:0]          dod_regs_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_FETCH,
    ST_SRC_EXT,
    ST_SRC_RD,
    ST_DST_EXT,
    ST_DST_RD,
    ST_EXEC
  } dod_state_t;

  typedef struct packed {
    dod_state_t  state;
    dod_instr_t  ir;
    logic [15:0] src_addr;
    logic [15:0] src_val;
    logic [15:0] dst_addr;
    logic [15:0] dst_val;
    dod_regs_t   regs;
    dod_mem_t    mem;
    logic        run;
    logic        step;
    logic        fault;
    dod_fmt_t    last_fmt;
    logic        busy;
    logic        ack;
    logic        waitreq;
    logic [31:0] rdata;
  } dod_core_t;

  // ****************************************
  // helpers
  // ****************************************
  // byte reads return one lane, word reads the whole word
  function automatic logic [15:0] mem_read(input dod_mem_t m, input logic [15:0] addr,
                                           input logic byte_op);
    logic [15:0] w;
    int          idx;
    w   = 16'h0000;
    idx = int'(addr[15:1]);
    if (idx < MEM_WORDS)
    begin
      w = m[idx];
    end
    if (byte_op)
    begin
      w = addr[0] ? {8'h00, w[15:8]} : {8'h00, w[7:0]};
    end
    return w;
  endfunction

  function automatic dod_mem_t mem_write(input dod_mem_t m, input logic [15:0] addr,
                                         input logic [15:0] data, input logic byte_op);
    dod_mem_t r;
    int       idx;
    r   = m;
    idx = int'(addr[15:1]);
    // writes outside the implemented words are dropped
    if (idx < MEM_WORDS)
    begin
      // byte writes touch one lane only
      if (!byte_op)
      begin
        r[idx] = data;
      end
      else if (addr[0])
      begin
        r[idx][15:8] = data[7:0];
      end
      else
      begin
        r[idx][7:0] = data[7:0];
      end
    end
    return r;
  endfunction

  function automatic logic [15:0] merge_lanes(input logic [15:0] old_v,
                                              input logic [15:0] new_v,
                                              input logic [1:0]  be);
    logic [15:0] r;
    r       = old_v;
    r[7:0]  = be[0] ? new_v[7:0] : old_v[7:0];
    r[15:8] = be[1] ? new_v[15:8] : old_v[15:8];
    return r;
  endfunction

  // ****************************************
  // state
  // ****************************************
  dod_core_t   q;
  dod_core_t   n;
  dod_instr_t  fetched;
  dod_fmt_t    fmt;
  dod_alu_t    alu;
  logic        bus_req;
  logic        is_ctrl;
  logic        is_status;
  logic        is_reg;
  logic        is_mem;
  logic        grant;
  logic        start;
  logic [15:0] inc;
  logic [15:0] rs_val;
  int          bus_idx;

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    n         = q;
    n.ack     = 1'b0;
    bus_req   = AVS_READ_I | AVS_WRITE_I;
    bus_idx   = int'(AVS_ADDRESS_I[7:2]);
    is_ctrl   = (AVS_ADDRESS_I == OFS_CTRL);
    is_status = (AVS_ADDRESS_I == OFS_STATUS);
    is_reg    = (AVS_ADDRESS_I[9:6] == OFS_REGS[9:6]);
    is_mem    = (AVS_ADDRESS_I[9:8] == OFS_MEM[9:8]) && (bus_idx < MEM_WORDS);
    // core-owned storage is only reachable while the core rests
    grant     = bus_req && !q.ack && (!(is_reg || is_mem) || q.state == ST_IDLE);
    // bus has priority so a held request cannot be starved by run mode
    start     = (q.state == ST_IDLE) && !q.fault && (q.run || q.step) && !bus_req && !q.ack;
    // field layout lives in the struct
    fetched   = dod_instr_t'(mem_read(q.mem, q.regs[REG_PC], 1'b0));
    fmt       = dod_decode_fmt(mem_read(q.mem, q.regs[REG_PC], 1'b0));
    alu       = dod_alu(q.ir.opcode, q.src_val, q.dst_val, q.ir.size_byte,
                        q.regs[REG_SR][SR_C]);
    rs_val    = q.regs[q.ir.src_reg];
    // pc always steps by a word, so immediates stay aligned
    inc       = (q.ir.size_byte && q.ir.src_reg != REG_PC) ? INC_BYTE : INC_WORD;

    // ****************************************
    // register bus
    // ****************************************
    if (grant)
    begin
      n.ack   = 1'b1;
      n.rdata = 32'h0000_0000;
      if (is_ctrl)
      begin
        n.rdata[CTRL_RUN]  = q.run;
        n.rdata[CTRL_STEP] = q.step;
      end
      else if (is_status)
      begin
        n.rdata[STAT_BUSY]  = q.busy;
        n.rdata[STAT_FAULT] = q.fault;
        n.rdata[5:4]        = q.last_fmt;
      end
      else if (is_reg)
      begin
        n.rdata[15:0] = q.regs[AVS_ADDRESS_I[5:2]];
      end
      else if (is_mem)
      begin
        n.rdata[15:0] = q.mem[bus_idx];
      end
    end

    // write lands on the edge that completes the transfer
    if (q.ack && AVS_WRITE_I)
    begin
      if (is_ctrl && AVS_BYTEENABLE_I[0])
      begin
        n.run = AVS_WRITEDATA_I[CTRL_RUN];
        if (AVS_WRITEDATA_I[CTRL_STEP])
        begin
          n.step = 1'b1;
        end
      end
      else if (is_status && AVS_BYTEENABLE_I[0] && AVS_WRITEDATA_I[STAT_FAULT])
      begin
        n.fault = 1'b0;
      end
      else if (is_reg)
      begin
        n.regs[AVS_ADDRESS_I[5:2]] = merge_lanes(q.regs[AVS_ADDRESS_I[5:2]],
                                                 AVS_WRITEDATA_I[15:0],
                                                 AVS_BYTEENABLE_I[1:0]);
      end
      else if (is_mem)
      begin
        n.mem[bus_idx] = merge_lanes(q.mem[bus_idx], AVS_WRITEDATA_I[15:0],
                                     AVS_BYTEENABLE_I[1:0]);
      end
    end

    // ****************************************
    // sequencer
    // ****************************************
    unique case (q.state)
      ST_IDLE:
      begin
        if (start)
        begin
          n.step  = 1'b0;
          n.state = ST_FETCH;
        end
      end
      ST_FETCH:
      begin
        // every word is sorted into one of the three formats, or into none when it matches no format
        n.last_fmt       = fmt;
        n.ir             = fetched;
        n.regs[REG_PC]   = q.regs[REG_PC] + INC_WORD;
        if (fmt == FMT_TWO)
        begin
          // indexed source needs its extension word first
          n.state = (fetched.src_mode_bits == SM_INDEX) ? ST_SRC_EXT : ST_SRC_RD;
        end
        else
        begin
          // only the two-operand format executes here; others halt the core
          n.fault = 1'b1;
          n.state = ST_IDLE;
        end
      end
      ST_SRC_EXT:
      begin
        n.src_addr     = rs_val + mem_read(q.mem, q.regs[REG_PC], 1'b0);
        n.regs[REG_PC] = q.regs[REG_PC] + INC_WORD;
        n.state        = ST_SRC_RD;
      end
      ST_SRC_RD:
      begin
        // size bit picks byte or word access
        unique case (q.ir.src_mode_bits)
          SM_REG:
          begin
            n.src_val = rs_val;
          end
          SM_INDEX:
          begin
            n.src_val = mem_read(q.mem, q.src_addr, q.ir.size_byte);
          end
          SM_INDIRECT:
          begin
            n.src_val = mem_read(q.mem, rs_val, q.ir.size_byte);
          end
          SM_AUTOINC:
          begin
            // immediate: pc points at the word after the opcode
            n.src_val               = mem_read(q.mem, rs_val, q.ir.size_byte);
            n.regs[q.ir.src_reg]    = rs_val + inc;
          end
        endcase
        // one dest mode bit: only register or indexed, never immediate
        n.state = (q.ir.dst_mode == DM_INDEX) ? ST_DST_EXT : ST_DST_RD;
      end
      ST_DST_EXT:
      begin
        n.dst_addr     = q.regs[q.ir.dst_reg] + mem_read(q.mem, q.regs[REG_PC], 1'b0);
        n.regs[REG_PC] = q.regs[REG_PC] + INC_WORD;
        n.state        = ST_DST_RD;
      end
      ST_DST_RD:
      begin
        // destination from its mode bit and register
        n.dst_val = (q.ir.dst_mode == DM_INDEX) ?
                    mem_read(q.mem, q.dst_addr, q.ir.size_byte) : q.regs[q.ir.dst_reg];
        n.state   = ST_EXEC;
      end
      ST_EXEC:
      begin
        // flags first, so a result aimed at the status register wins
        if (alu.upd_flags)
        begin
          n.regs[REG_SR][SR_C] = alu.c;
          n.regs[REG_SR][SR_Z] = alu.z;
          n.regs[REG_SR][SR_N] = alu.n;
          n.regs[REG_SR][SR_V] = alu.v;
        end
        // compare and bit test skip the write
        if (alu.wr_dst)
        begin
          if (q.ir.dst_mode == DM_REG)
          begin
            // byte results clear the upper half of a register
            n.regs[q.ir.dst_reg] = q.ir.size_byte ? {8'h00, alu.result[7:0]} : alu.result;
          end
          else
          begin
            n.mem = mem_write(n.mem, q.dst_addr, alu.result, q.ir.size_byte);
          end
        end
        n.state = ST_IDLE;
      end
    endcase

    n.busy    = (n.state != ST_IDLE);
    n.waitreq = !n.ack;
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge CLK_I)
  begin
    if (!RSTN_I)
    begin
      q         <= '0;
      q.waitreq <= 1'b1;
      q.last_fmt <= FMT_NONE;
    end
    else
    begin
      q <= n;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign AVS_READDATA_O    = q.rdata;
  assign AVS_WAITREQUEST_O = q.waitreq;
  assign BUSY_O            = q.busy;
  assign FAULT_O           = q.fault;

endmodule
`default_nettype wire

/* File: test/dod_core_sva.sv */
// bus and status checker for the dual-operand decode/execute core
`timescale 1ns/10ps
`default_nettype none
module dod_core_sva
  import dod_pkg::*;
#(
  parameter int MEM_WORDS = 64
)
(
  // clock and reset
  input wire logic        CLK_I,
  input wire logic        RSTN_I,
  // avalon-mm slave
  input wire logic [9:0]  AVS_ADDRESS_I,
  input wire logic        AVS_READ_I,
  input wire logic        AVS_WRITE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  input wire logic [3:0]  AVS_BYTEENABLE_I,
  input wire logic [31:0] AVS_READDATA_O,
  input wire logic        AVS_WAITREQUEST_O,
  // core status
  input wire logic        BUSY_O,
  input wire logic        FAULT_O
);
  // ****************************************
  // helpers and properties
  // ****************************************
  logic ack;
  logic req;
  logic unm;
  logic clr;
  assign ack = !AVS_WAITREQUEST_O;
  assign req = AVS_READ_I || AVS_WRITE_I;
  // gaps between blocks and memory past its end read as zero
  assign unm = (AVS_ADDRESS_I inside {[10'h008:10'h03F], [10'h080:10'h0FF]}) ||
               (int'(AVS_ADDRESS_I) >= int'(OFS_MEM) + 4 * MEM_WORDS);
  assign clr = ack && AVS_WRITE_I && AVS_ADDRESS_I == OFS_STATUS && AVS_WRITEDATA_I[STAT_FAULT];
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RSTN_I);
  property p_wait_one;
    $fell(AVS_WAITREQUEST_O) |=> AVS_WAITREQUEST_O;
  endproperty
  property p_ack_cause;
    ack |-> $past(req);
  endproperty
  property p_rd_hold;
    AVS_WAITREQUEST_O |-> $stable(AVS_READDATA_O);
  endproperty
  property p_hi_zero;
    ack && AVS_READ_I |-> AVS_READDATA_O[31:16] == 16'h0000;
  endproperty
  property p_unmapped;
    ack && AVS_READ_I && unm |-> AVS_READDATA_O == 32'h0000_0000;
  endproperty
  property p_regs_idle;
    ack && AVS_ADDRESS_I >= OFS_REGS |-> !BUSY_O && !$past(BUSY_O);
  endproperty
  property p_fault_keep;
    FAULT_O && !clr |=> FAULT_O;
  endproperty
  property p_no_run_fault;
    $rose(BUSY_O) |-> !$past(FAULT_O);
  endproperty
  property p_busy_end;
    $rose(BUSY_O) |-> ##[1:6] !BUSY_O;
  endproperty
  a_wait_one: assert property (p_wait_one)
    else $error("waitrequest low for more than one cycle");
  a_ack_cause: assert property (p_ack_cause)
    else $error("answer without a request");
  a_rd_hold: assert property (p_rd_hold)
    else $error("read data changed outside an answer");
  a_hi_zero: assert property (p_hi_zero)
    else $error("upper half of read data not zero");
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read returned data");
  a_regs_idle: assert property (p_regs_idle)
    else $error("register access answered while executing");
  a_fault_keep: assert property (p_fault_keep)
    else $error("fault dropped without a clear");
  a_no_run_fault: assert property (p_no_run_fault)
    else $error("execution started while faulted");
  a_busy_end: assert property (p_busy_end)
    else $error("instruction ran longer than six cycles");
  c_read: cover property (ack && AVS_READ_I);
  c_exec: cover property ($rose(BUSY_O));
  c_fault: cover property ($rose(FAULT_O));
endmodule
bind dod_core dod_core_sva #(.MEM_WORDS(MEM_WORDS)) dod_core_sva_i (
  .CLK_I(CLK_I), .RSTN_I(RSTN_I), .AVS_ADDRESS_I(AVS_ADDRESS_I), .AVS_READ_I(AVS_READ_I),
  .AVS_WRITE_I(AVS_WRITE_I), .AVS_WRITEDATA_I(AVS_WRITEDATA_I),
  .AVS_BYTEENABLE_I(AVS_BYTEENABLE_I), .AVS_READDATA_O(AVS_READDATA_O),
  .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O), .BUSY_O(BUSY_O), .FAULT_O(FAULT_O));
`default_nettype wire

/* File: test/dod_host_model.sv */
// avalon-mm host that loads programs and reads results of the core
`timescale 1ns/10ps
`default_nettype none
module dod_host_model
(
  // clock
  input  wire logic        clk_i,
  // avalon-mm master
  output logic [9:0]       address_o,
  output logic             read_o,
  output logic             write_o,
  output logic [31:0]      writedata_o,
  output logic [3:0]       byteenable_o,
  input  wire logic        waitrequest_i,
  input  wire logic [31:0] readdata_i
);
  initial
  begin
    address_o    = 10'h000;
    read_o       = 1'b0;
    write_o      = 1'b0;
    writedata_o  = 32'h0000_0000;
    byteenable_o = 4'h0;
  end
  // results aimed only at writable places, except where loss is probed
  task automatic xfer(input logic [9:0] a, input logic w, input logic [15:0] d,
                      output logic [31:0] q);
    @(posedge clk_i);
    address_o    <= a;
    read_o       <= !w;
    write_o      <= w;
    writedata_o  <= {16'h0000, d};
    byteenable_o <= 4'h3;
    @(posedge clk_i);
    while (waitrequest_i)
    begin
      @(posedge clk_i);
    end
    q = readdata_i;
    read_o  <= 1'b0;
    write_o <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* File: test/tb_dod_core.sv */
// self-checking bench of the dual-operand core over its register bus
`timescale 1ns/10ps
`default_nettype none
module tb_dod_core
  import dod_pkg::*;
;
  logic        CLK_I;
  logic        RSTN_I;
  logic [9:0]  adr;
  logic        rd_en;
  logic        wr_en;
  logic [31:0] wdat;
  logic [3:0]  be;
  logic [31:0] rdat;
  logic        wait_rq;
  int          errors;
  int          n_checks;
  logic        busy;
  logic        fault;
  logic [1:0]  fmt_exp;

  dod_core #(.MEM_WORDS(16)) dod_core_i (
    .CLK_I(CLK_I), .RSTN_I(RSTN_I), .AVS_ADDRESS_I(adr), .AVS_READ_I(rd_en),
    .AVS_WRITE_I(wr_en), .AVS_WRITEDATA_I(wdat), .AVS_BYTEENABLE_I(be),
    .AVS_READDATA_O(rdat), .AVS_WAITREQUEST_O(wait_rq), .BUSY_O(busy), .FAULT_O(fault));
  dod_host_model dod_host_model_i (
    .clk_i(CLK_I), .address_o(adr), .read_o(rd_en), .write_o(wr_en), .writedata_o(wdat),
    .byteenable_o(be), .waitrequest_i(wait_rq), .readdata_i(rdat));

  initial
  begin
    CLK_I = 1'b0;
    forever #5 CLK_I = ~CLK_I;
  end

  // ****************************************
  // tasks and reference model
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    if (errors == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wr(input logic [9:0] a, input logic [15:0] d);
    logic [31:0] q;
    dod_host_model_i.xfer(a, 1'b1, d, q);
  endtask
  task automatic rdc(input logic [9:0] a, input logic [31:0] e);
    logic [31:0] q;
    dod_host_model_i.xfer(a, 1'b0, 16'h0000, q);
    check(q, e);
  endtask
  function automatic logic [9:0] ra(input int n);
    return OFS_REGS + 10'(4 * n);
  endfunction
  function automatic int bcd(input logic [15:0] x);
    return x[15:12] * 1000 + x[11:8] * 100 + x[7:4] * 10 + x[3:0];
  endfunction
  // returns {writes destination, result, new status word}
  function automatic logic [32:0] ref_exec(input logic [3:0] op, input logic b,
                                           input logic [15:0] si, di, sr);
    logic [15:0] m, s, d, a, r;
    logic [16:0] sm;
    logic        c, v, ci, wr_d, upd;
    int          k, t;
    m = b ? 16'h00FF : 16'hFFFF;
    s = si & m;
    d = di & m;
    k = b ? 7 : 15;
    r = 16'h0000;
    {c, v, wr_d, upd} = 4'b0011;
    case (op)
      OP_MOVE: {r, upd} = {s, 1'b0};
      OP_BIT_CLEAR: {r, upd} = {~s & d, 1'b0};
      OP_BIT_SET: {r, upd} = {s | d, 1'b0};
      OP_BIT_TEST, OP_AND: {r, wr_d} = {s & d, op == OP_AND};
      OP_XOR: {r, v} = {s ^ d, s[k] & d[k]};
      OP_DECIMAL_ADD:
      begin
        t = bcd(s) + bcd(d) + int'(sr[SR_C]);
        c = t >= (b ? 100 : 10000);
        t = t % (b ? 100 : 10000);
        r = {4'(t / 1000), 4'(t / 100 % 10), 4'(t / 10 % 10), 4'(t % 10)};
      end
      default:
      begin
        a    = (op >= OP_SUBTRACT_CARRY) ? ~s & m : s;
        ci   = (op == OP_ADD) ? 1'b0 : (op inside {OP_SUBTRACT, OP_COMPARE}) ? 1'b1 : sr[SR_C];
        sm   = {1'b0, a} + {1'b0, d} + {16'h0000, ci};
        r    = sm[15:0] & m;
        c    = b ? sm[8] : sm[16];
        v    = (a[k] == d[k]) && (r[k] != d[k]);
        wr_d = op != OP_COMPARE;
      end
    endcase
    // logic results carry out when non-zero
    if (op inside {OP_BIT_TEST, OP_AND, OP_XOR})
      c = r != 16'h0000;
    return {wr_d, r, upd ? {sr[15:9], v, sr[7:3], r[k], r == 16'h0000, c} : sr};
  endfunction
  task automatic prog(input logic [15:0] w0, w1);
    wr(OFS_MEM, w0);
    wr(OFS_MEM + 10'h004, w1);
    wr(ra(0), 16'h0000);
    wr(OFS_CTRL, 16'h0002);
  endtask
  // register-to-register op, R4 source, R5 destination
  task automatic run_op(input logic [3:0] op, input logic b, input logic [15:0] s, d, sr);
    logic [32:0] e;
    e = ref_exec(op, b, s, d, sr);
    wr(ra(4), s);
    wr(ra(5), d);
    wr(ra(2), sr);
    prog({op, 4'h4, 1'b0, b, 2'b00, 4'h5}, 16'h0000);
    // format field still shows the previous fetch while this one is under way
    rdc(OFS_STATUS, {26'h000_0000, fmt_exp, 4'h1});
    check({31'h0000_0000, busy}, 32'h0000_0001);
    fmt_exp = FMT_TWO;
    rdc(ra(5), {16'h0000, e[32] ? e[31:16] : d});
    rdc(ra(2), {16'h0000, e[15:0]});
    rdc(ra(0), 32'h0000_0002);
  endtask

  // ****************************************
  // test sequence
  // ****************************************
  initial
  begin
    repeat (20000) @(posedge CLK_I);
    errors++;
    end_of_test();
  end
  initial
  begin
    errors   = 0;
    n_checks = 0;
    fmt_exp  = FMT_NONE;
    RSTN_I   = 1'b0;
    repeat (3) @(posedge CLK_I);
    RSTN_I <= 1'b1;
    rdc(OFS_CTRL, 32'h0000_0000);
    rdc(OFS_STATUS, 32'h0000_0030);
    rdc(ra(0), 32'h0000_0000);
    rdc(OFS_MEM, 32'h0000_0000);
    wr(10'h140, 16'hBEEF);
    rdc(10'h140, 32'h0000_0000);
    rdc(10'h008, 32'h0000_0000);
    run_op(OP_MOVE, 1'b0, 16'h1234, 16'h5555, 16'h0107);
    run_op(OP_ADD, 1'b0, 16'h7FFF, 16'h0001, 16'h0000);
    run_op(OP_ADD, 1'b1, 16'h12FF, 16'h3401, 16'h0000);
    run_op(OP_ADD_CARRY, 1'b0, 16'hFFFF, 16'h0000, 16'h0001);
    run_op(OP_SUBTRACT, 1'b0, 16'h0001, 16'h0000, 16'h0000);
    run_op(OP_SUBTRACT_CARRY, 1'b0, 16'h0001, 16'h0003, 16'h0000);
    run_op(OP_COMPARE, 1'b0, 16'h8000, 16'h0001, 16'h0000);
    run_op(OP_DECIMAL_ADD, 1'b0, 16'h0999, 16'h0001, 16'h0001);
    run_op(OP_DECIMAL_ADD, 1'b1, 16'h0099, 16'h0001, 16'h0000);
    run_op(OP_BIT_TEST, 1'b0, 16'h00F0, 16'h0F0F, 16'h0100);
    run_op(OP_BIT_CLEAR, 1'b0, 16'h00F0, 16'h0FFF, 16'h0007);
    run_op(OP_BIT_SET, 1'b1, 16'h0F0F, 16'hF0F0, 16'h0000);
    run_op(OP_XOR, 1'b0, 16'h8001, 16'h8000, 16'h0000);
    run_op(OP_AND, 1'b1, 16'h0080, 16'h0081, 16'h0100);
    // immediate source: mode 11 on the program counter
    prog(16'h4036, 16'h1234);
    rdc(ra(6), 32'h0000_1234);
    rdc(ra(0), 32'h0000_0004);
    // indexed source: word at R7 plus extension word
    wr(ra(7), 16'h0010);
    wr(OFS_MEM + 10'h024, 16'hABCD);
    prog(16'h4718, 16'h0002);
    rdc(ra(8), 32'h0000_ABCD);
    rdc(ra(0), 32'h0000_0004);
    // indirect byte source into the high byte of an indexed destination
    wr(ra(9), 16'h0012);
    wr(ra(10), 16'h0010);
    wr(OFS_MEM + 10'h020, 16'h1200);
    prog(16'hD9EA, 16'h0001);
    rdc(OFS_MEM + 10'h020, 32'h0000_DF00);
    rdc(ra(0), 32'h0000_0004);
    // one-operand word halts the core until the fault is cleared
    prog(16'h1000, 16'h0000);
    rdc(ra(0), 32'h0000_0002);
    rdc(OFS_STATUS, 32'h0000_0012);
    check({31'h0000_0000, fault}, 32'h0000_0001);
    wr(OFS_STATUS, 16'h0002);
    rdc(OFS_STATUS, 32'h0000_0010);
    check({31'h0000_0000, fault}, 32'h0000_0000);
    // jump-format word halts the core as well
    prog(16'h2000, 16'h0000);
    rdc(ra(0), 32'h0000_0002);
    rdc(OFS_STATUS, 32'h0000_0022);
    wr(OFS_STATUS, 16'h0002);
    rdc(OFS_STATUS, 32'h0000_0020);
    end_of_test();
  end
endmodule
`default_nettype wire
